/* pkg/meter_flags_pkg.sv */
// constants and carrier types for the meter event status block
package meter_flags_pkg;

  // ---------------------------------------------------------------
  // bus and register indices (byte address = 4 * index)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 18;
  localparam int          IDX_W           = 16;
  localparam int          WORD_LSB        = 2;
  localparam logic [15:0] IDX_STATUS      = 16'he503;
  localparam logic [15:0] IDX_MASK        = 16'he50b;
  localparam logic [15:0] IDX_PHASE_IDLE  = 16'he608;
  localparam logic [15:0] IDX_PHASE_EVENT = 16'he600;
  localparam logic [15:0] IDX_CURR_PEAK   = 16'he500;
  localparam logic [15:0] IDX_VOLT_PEAK   = 16'he501;
  localparam logic [15:0] IDX_THRESHOLD   = 16'he52a;
  localparam logic [15:0] IDX_CONFIG      = 16'he618;

  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int B_TOTAL_IDLE   = 0;
  localparam int B_FUND_IDLE    = 1;
  localparam int B_APP_IDLE     = 2;
  localparam int B_ZX_TIMEOUT   = 3;
  localparam int B_ZX_SEEN      = 9;
  localparam int B_RESET_DONE   = 15;
  localparam int B_SAG          = 16;
  localparam int B_HIGH_CURR    = 17;
  localparam int B_HIGH_VOLT    = 18;
  localparam int B_ORDER_ERR    = 19;
  localparam int B_IMBALANCE    = 20;
  localparam int B_CURR_PEAK    = 23;
  localparam int B_VOLT_PEAK    = 24;
  localparam logic [31:0] STATUS_RESET = 32'h0020_8000;
  localparam logic [31:0] FLAG_MASK    = 32'h019f_ffff;
  localparam logic [31:0] RSVD_ONES    = 32'h0020_0000;

  // ---------------------------------------------------------------
  // phase register layouts and widths
  // ---------------------------------------------------------------
  localparam int P_TOTAL_IDLE = 0;
  localparam int P_FUND_IDLE  = 3;
  localparam int P_APP_IDLE   = 6;
  localparam int P_HIGH_CURR  = 3;
  localparam int P_HIGH_VOLT  = 9;
  localparam int P_SAG        = 12;
  localparam int PEAK_W       = 27;
  localparam int MAG_W        = 24;
  localparam int CFG_SOFTWARE_RESET_BIT    = 7;

  // power states, normal first
  typedef enum logic [1:0] {
    normal_power_state, reduced_power_state_one,
    reduced_power_state_two, sleep_power_state
  } pwr_state_t;

  // event pulses from the measurement datapath
  typedef struct packed {
    logic [2:0]        total_idle_phases;
    logic [2:0]        fundamental_idle_phases;
    logic [2:0]        apparent_idle_phases;
    logic [5:0]        crossing_timeout;
    logic [5:0]        crossing_seen;
    logic [2:0]        volt_rise;
    logic [2:0]        sag_phases;
    logic [2:0]        high_current_phases;
    logic [2:0]        high_voltage_phases;
    logic              current_peak_done;
    logic              voltage_peak_done;
    logic [PEAK_W-1:0] current_peak;
    logic [PEAK_W-1:0] voltage_peak;
  } event_in_t;

  // software visible contents
  typedef struct packed {
    logic [31:0]       status;
    logic [31:0]       mask;
    logic [8:0]        phase_idle;
    logic [14:0]       phase_event;
    logic [PEAK_W-1:0] curr_peak;
    logic [PEAK_W-1:0] volt_peak;
    logic [MAG_W-1:0]  threshold;
  } regs_t;

  localparam regs_t REGS_RESET = '{status: STATUS_RESET, default: '0};

  // whole state of the top module
  typedef struct packed {
    regs_t       regs;
    logic [1:0]  prev_pwr;
    logic        waitreq;
    logic [31:0] readdata;
    logic        irq_n;
  } top_state_t;

  // phase order checker states
  typedef enum logic {order_idle, order_wait} order_state_t;

  typedef struct packed {
    order_state_t st;
    logic         err;
  } order_t;

endpackage

/* logic/phase_order_check.sv */
// phase sequence checker on rising voltage crossings
`timescale 1ns/1ps
module phase_order_check (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [2:0] volt_rise,
  output logic            order_err
);

  meter_flags_pkg::order_t s_q;
  meter_flags_pkg::order_t s_d;

  // --------------------------------------------------
  // after phase a, the next rising edge must be b
  // --------------------------------------------------
  always_comb begin
    s_d     = s_q;
    s_d.err = 1'b0;
    case (s_q.st)
      meter_flags_pkg::order_idle: begin
        if (volt_rise[0]) begin
          s_d.st = meter_flags_pkg::order_wait;
        end
      end
      meter_flags_pkg::order_wait: begin
        if (volt_rise[2] && !volt_rise[1]) begin
          s_d.err = 1'b1;
          s_d.st  = meter_flags_pkg::order_idle;
        end else if (volt_rise[1]) begin
          s_d.st = meter_flags_pkg::order_idle;
        end
      end
      default: s_d.st = meter_flags_pkg::order_idle;
    endcase
  end

  // state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: meter_flags_pkg::order_idle, err: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign order_err = s_q.err;

  a_order_err_c: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_q.st == meter_flags_pkg::order_wait && volt_rise == 3'b100) |=> order_err)
    else $error("c after a not flagged");

endmodule // phase_order_check

/* logic/meter_event_status_flags.sv */
// second event status register with interrupt and register slave
`timescale 1ns/1ps
// Contract
// - bit 0: total power no-load, phases
// - bit 1: fundamental no-load, phases, variant zero
// - bit 2: apparent power no-load, phases
// - bits 3-8: missing crossing per signal
// - bits 9-14: crossing detected per signal
// - bit 15 reset complete after any reset
// - reset complete drives interrupt low unmaskable
// - bit 16 sag with phases
// - bit 17 overcurrent with phases
// - bit 18 overvoltage with phases
// - bit 19 phase a then c error
// - bit 20 neutral mismatch over threshold
// - bit 21 one, 22 and 31:25 zero
// - bit 23 current peak period ended
// - bit 24 voltage peak period ended
module meter_event_status_flags #(
  parameter bit HAS_FUNDAMENTAL = 1'b1,
  parameter bit HAS_NEUTRAL     = 1'b1
) (
  input  wire logic                                core_clk,
  input  wire logic                                nrst,
  input  wire logic [meter_flags_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                                avs_read,
  input  wire logic                                avs_write,
  input  wire logic [31:0]                         avs_writedata,
  input  wire logic [3:0]                          avs_byteenable,
  output logic [31:0]                              avs_readdata,
  output logic                                     avs_waitrequest,
  input  wire meter_flags_pkg::event_in_t          events,
  input  wire logic [meter_flags_pkg::MAG_W-1:0]   summed_phase_current,
  input  wire logic [meter_flags_pkg::MAG_W-1:0]   neutral_current_sample,
  input  wire logic                                magnitude_valid,
  input  wire meter_flags_pkg::pwr_state_t         power_state,
  output logic                                     second_interrupt_pin_n
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // magnitude of a difference without wrap
  function automatic logic [meter_flags_pkg::MAG_W-1:0] abs_diff(
    input logic [meter_flags_pkg::MAG_W-1:0] a,
    input logic [meter_flags_pkg::MAG_W-1:0] b);
    return (a > b) ? (a - b) : (b - a);
  endfunction

  meter_flags_pkg::top_state_t s_q;
  meter_flags_pkg::top_state_t s_d;
  logic                        order_err;
  logic [31:0]                 set_vec;
  logic [31:0]                 clr_vec;
  logic [31:0]                 wmask;
  logic [meter_flags_pkg::IDX_W-1:0] idx;
  logic                        bus_req;
  logic                        accept;
  logic                        restart;
  logic                        imbalance;

  // ---------------------------------------------------------------
  // phase sequence checker
  // ---------------------------------------------------------------
  phase_order_check u_order (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .volt_rise (events.volt_rise),
    .order_err (order_err)
  );

  // bus decode; the request is taken on the edge where waitrequest is low
  assign bus_req = avs_read | avs_write;
  assign accept  = bus_req & ~s_q.waitreq;
  assign idx     = avs_address[meter_flags_pkg::ADDR_W-1:meter_flags_pkg::WORD_LSB];
  assign wmask   = lane_mask(avs_byteenable);

  assign imbalance = HAS_NEUTRAL & magnitude_valid &
    (abs_diff(summed_phase_current, neutral_current_sample) > s_q.regs.threshold);

  // ---------------------------------------------------------------
  // event collection into one set vector
  // ---------------------------------------------------------------
  always_comb begin
    set_vec = '0;
    set_vec[meter_flags_pkg::B_TOTAL_IDLE] = |events.total_idle_phases;
    set_vec[meter_flags_pkg::B_FUND_IDLE]  = HAS_FUNDAMENTAL &
                                             (|events.fundamental_idle_phases);
    set_vec[meter_flags_pkg::B_APP_IDLE]   = |events.apparent_idle_phases;
    set_vec[meter_flags_pkg::B_ZX_TIMEOUT +: 6] = events.crossing_timeout;
    set_vec[meter_flags_pkg::B_ZX_SEEN +: 6]    = events.crossing_seen;
    set_vec[meter_flags_pkg::B_SAG]        = |events.sag_phases;
    set_vec[meter_flags_pkg::B_HIGH_CURR]  = |events.high_current_phases;
    set_vec[meter_flags_pkg::B_HIGH_VOLT]  = |events.high_voltage_phases;
    set_vec[meter_flags_pkg::B_ORDER_ERR]  = order_err;
    set_vec[meter_flags_pkg::B_IMBALANCE]  = imbalance;
    set_vec[meter_flags_pkg::B_CURR_PEAK]  = events.current_peak_done;
    set_vec[meter_flags_pkg::B_VOLT_PEAK]  = events.voltage_peak_done;
  end

  // write one to clear, masked by lanes
  assign clr_vec = (accept && avs_write && idx == meter_flags_pkg::IDX_STATUS) ?
                   (avs_writedata & wmask & meter_flags_pkg::FLAG_MASK) : '0;

  // software reset or return to normal power reloads defaults
  assign restart =
    (accept && avs_write && idx == meter_flags_pkg::IDX_CONFIG &&
     avs_byteenable[0] && avs_writedata[meter_flags_pkg::CFG_SOFTWARE_RESET_BIT]) ||
    (s_q.prev_pwr != meter_flags_pkg::normal_power_state &&
     power_state == meter_flags_pkg::normal_power_state);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.prev_pwr = power_state;

    // one wait cycle per request, then release
    s_d.waitreq = 1'b1;
    if (bus_req && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      case (idx)
        meter_flags_pkg::IDX_STATUS:
          s_d.readdata = (s_q.regs.status & meter_flags_pkg::FLAG_MASK) |
                         meter_flags_pkg::RSVD_ONES;
        meter_flags_pkg::IDX_MASK:        s_d.readdata = s_q.regs.mask;
        meter_flags_pkg::IDX_PHASE_IDLE:  s_d.readdata = {23'h000000, s_q.regs.phase_idle};
        meter_flags_pkg::IDX_PHASE_EVENT: s_d.readdata = {17'h00000, s_q.regs.phase_event};
        meter_flags_pkg::IDX_CURR_PEAK:   s_d.readdata = {5'h00, s_q.regs.curr_peak};
        meter_flags_pkg::IDX_VOLT_PEAK:   s_d.readdata = {5'h00, s_q.regs.volt_peak};
        meter_flags_pkg::IDX_THRESHOLD:   s_d.readdata = {8'h00, s_q.regs.threshold};
        default:                          s_d.readdata = 32'h0000_0000;
      endcase
    end

    // writable control registers
    if (accept && avs_write) begin
      case (idx)
        meter_flags_pkg::IDX_MASK:
          s_d.regs.mask = (s_q.regs.mask & ~wmask) | (avs_writedata & wmask);
        meter_flags_pkg::IDX_THRESHOLD:
          s_d.regs.threshold = (s_q.regs.threshold & ~wmask[meter_flags_pkg::MAG_W-1:0]) |
                               (avs_writedata[meter_flags_pkg::MAG_W-1:0] &
                                wmask[meter_flags_pkg::MAG_W-1:0]);
        default: ;
      endcase
    end

    // sticky flags, set wins over clear
    s_d.regs.status = ((s_q.regs.status & ~clr_vec) | set_vec) &
                      meter_flags_pkg::FLAG_MASK;

    // per-phase detail registers accumulate phases
    s_d.regs.phase_idle[meter_flags_pkg::P_TOTAL_IDLE +: 3] =
      s_q.regs.phase_idle[meter_flags_pkg::P_TOTAL_IDLE +: 3] | events.total_idle_phases;
    s_d.regs.phase_idle[meter_flags_pkg::P_FUND_IDLE +: 3] =
      s_q.regs.phase_idle[meter_flags_pkg::P_FUND_IDLE +: 3] |
      (events.fundamental_idle_phases & {3{HAS_FUNDAMENTAL}});
    s_d.regs.phase_idle[meter_flags_pkg::P_APP_IDLE +: 3] =
      s_q.regs.phase_idle[meter_flags_pkg::P_APP_IDLE +: 3] | events.apparent_idle_phases;
    s_d.regs.phase_event[meter_flags_pkg::P_HIGH_CURR +: 3] =
      s_q.regs.phase_event[meter_flags_pkg::P_HIGH_CURR +: 3] | events.high_current_phases;
    s_d.regs.phase_event[meter_flags_pkg::P_HIGH_VOLT +: 3] =
      s_q.regs.phase_event[meter_flags_pkg::P_HIGH_VOLT +: 3] | events.high_voltage_phases;
    s_d.regs.phase_event[meter_flags_pkg::P_SAG +: 3] =
      s_q.regs.phase_event[meter_flags_pkg::P_SAG +: 3] | events.sag_phases;

    // capture current peak at period end
    if (events.current_peak_done) begin
      s_d.regs.curr_peak = events.current_peak;
    end
    // capture voltage peak at period end
    if (events.voltage_peak_done) begin
      s_d.regs.volt_peak = events.voltage_peak;
    end

    // defaults reloaded, reset complete comes back set
    if (restart) begin
      s_d.regs = meter_flags_pkg::REGS_RESET;
    end

    // enabled flags hold the pin low
    s_d.irq_n = ~((|(s_d.regs.status & s_d.regs.mask)) |
                  s_d.regs.status[meter_flags_pkg::B_RESET_DONE]);
  end

  // ---------------------------------------------------------------
  // state register; reset flag and low pin come out of hardware reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{regs: meter_flags_pkg::REGS_RESET, prev_pwr: 2'h0,
               waitreq: 1'b1, readdata: 32'h0000_0000, irq_n: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata           = s_q.readdata;
  assign avs_waitrequest        = s_q.waitreq;
  assign second_interrupt_pin_n = s_q.irq_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------

  a_total_idle_set: assert property (@(posedge core_clk) disable iff (!nrst)
    (|events.total_idle_phases && !restart) |=> s_q.regs.status[0])
    else $error("total no-load not flagged");

  a_fund_idle_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    !HAS_FUNDAMENTAL |-> !s_q.regs.status[1])
    else $error("fundamental flag set without fundamental");

  a_timeout_lane: assert property (@(posedge core_clk) disable iff (!nrst)
    (events.crossing_timeout[2] && !restart) |=> s_q.regs.status[5])
    else $error("phase c voltage timeout not flagged");

  a_clear_one: assert property (@(posedge core_clk) disable iff (!nrst)
    (clr_vec[12] && !set_vec[12]) |=> !s_q.regs.status[12])
    else $error("write one did not clear");

  a_flag_sticky: assert property (@(posedge core_clk) disable iff (!nrst)
    (s_q.regs.status[16] && !clr_vec[16] && !restart) |=> s_q.regs.status[16])
    else $error("sag flag dropped on its own");

  a_reset_irq: assert property (@(posedge core_clk) disable iff (!nrst)
    s_q.regs.status[15] |-> !second_interrupt_pin_n)
    else $error("reset complete did not hold pin low");

  a_irq_release: assert property (@(posedge core_clk) disable iff (!nrst)
    (((s_q.regs.status & s_q.regs.mask) == '0) && !s_q.regs.status[15])
      |-> second_interrupt_pin_n)
    else $error("pin low with no enabled flag");

  a_reserved_read: assert property (@(posedge core_clk) disable iff (!nrst)
    (bus_req && s_q.waitreq && idx == meter_flags_pkg::IDX_STATUS)
      |=> (avs_readdata[22:21] == 2'b01 && avs_readdata[31:25] == 7'h00))
    else $error("reserved status bits wrong");

  a_imbalance_set: assert property (@(posedge core_clk) disable iff (!nrst)
    (imbalance && !restart) |=> s_q.regs.status[20])
    else $error("imbalance not flagged");

  a_peak_capture: assert property (@(posedge core_clk) disable iff (!nrst)
    (events.current_peak_done && !restart) |=>
      (s_q.regs.status[23] && s_q.regs.curr_peak == $past(events.current_peak)))
    else $error("current peak not captured");

  // bus answer one cycle after request, then released
  a_wait_one: assert property (@(posedge core_clk) disable iff (!nrst)
    (bus_req && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest handshake wrong");

endmodule // meter_event_status_flags

/* testbench/avs_host_model.sv */
// host side bus master model for the event status registers
`timescale 1ns/1ps
module avs_host_model (
  input  wire logic                               core_clk,
  output logic [meter_flags_pkg::ADDR_W-1:0]      avs_address,
  output logic                                    avs_read,
  output logic                                    avs_write,
  output logic [31:0]                             avs_writedata,
  output logic [3:0]                              avs_byteenable,
  input  wire logic [31:0]                        avs_readdata,
  input  wire logic                               avs_waitrequest
);
  // ---------------------------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------------------------
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = '0;
  end

  // one transfer, held until waitrequest is sampled low at an edge
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      input logic [3:0] be, output logic [31:0] rd);
    @(posedge core_clk);
    avs_address    <= {idx, 2'b00};
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_writedata  <= wd;
    avs_byteenable <= be;
    // no cycle count assumed; only the bench watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    // released lines show junk, never the last value
    avs_address    <= ~{idx, 2'b00};
    avs_writedata  <= ~wd;
    avs_byteenable <= ~be;
  endtask
endmodule // avs_host_model

/* testbench/meter_event_status_flags_tb_top.sv */
// self checking bench for the meter event status block
`timescale 1ns/1ps
module meter_event_status_flags_tb_top;
  localparam logic [15:0] ST = meter_flags_pkg::IDX_STATUS;
  localparam logic [15:0] MK = meter_flags_pkg::IDX_MASK;
  localparam logic [31:0] R  = meter_flags_pkg::RSVD_ONES;
  logic                       core_clk = 1'b0;
  logic                       nrst = 1'b0;
  logic [17:0]                adr;
  logic                       rd_s, wr_s, wreq, pin_n, mv = 1'b0;
  logic [31:0]                wd, rdat, rd;
  logic [31:0]                rdat2;
  logic [3:0]                 be;
  logic [23:0]                sum = '0, neu = '0;
  meter_flags_pkg::event_in_t ev = '0;
  meter_flags_pkg::pwr_state_t pwr = meter_flags_pkg::normal_power_state;
  int                         failures = 0;
  int                         checked = 0;

  // 50 MHz clock
  always #10 core_clk = ~core_clk;

  avs_host_model host (.core_clk(core_clk), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wreq));
  meter_event_status_flags uut (.core_clk(core_clk), .nrst(nrst), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .events(ev), .summed_phase_current(sum),
    .neutral_current_sample(neu), .magnitude_valid(mv), .power_state(pwr),
    .second_interrupt_pin_n(pin_n));
  // variant without fundamental or neutral channel on the same bus, read data only
  meter_event_status_flags #(.HAS_FUNDAMENTAL(1'b0), .HAS_NEUTRAL(1'b0)) uut_lite (
    .core_clk(core_clk), .nrst(nrst), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat2), .avs_waitrequest(),
    .events(ev), .summed_phase_current(sum), .neutral_current_sample(neu),
    .magnitude_valid(mv), .power_state(pwr), .second_interrupt_pin_n());

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input string what, input logic [15:0] idx, input logic [31:0] exp);
    host.xfer(1'b0, idx, 32'h0, 4'hf, rd);
    chk(what, rd, exp);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] b);
    host.xfer(1'b1, idx, d, b, rd);
  endtask
  // pin is registered, so look one edge later once settled
  task automatic pinchk(input logic exp);
    @(posedge core_clk);
    #1;
    chk("irq pin", {31'h0, pin_n}, {31'h0, exp});
  endtask
  task automatic pulse(input meter_flags_pkg::event_in_t e);
    @(posedge core_clk);
    ev <= e;
    @(posedge core_clk);
    ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic mag(input logic [23:0] a, input logic [23:0] n);
    @(posedge core_clk);
    sum <= a;
    neu <= n;
    mv  <= 1'b1;
    @(posedge core_clk);
    mv  <= 1'b0;
  endtask
  // one stimulus pattern per flag bit, phases spread over a, b, c
  function automatic meter_flags_pkg::event_in_t ev_for(int b);
    meter_flags_pkg::event_in_t e;
    e = '0;
    case (b)
      0: e.total_idle_phases = 3'h1;
      1: e.fundamental_idle_phases = 3'h2;
      2: e.apparent_idle_phases = 3'h4;
      16: e.sag_phases = 3'h1;
      17: e.high_current_phases = 3'h2;
      18: e.high_voltage_phases = 3'h4;
      23: begin
        e.current_peak_done = 1'b1;
        e.current_peak = 27'h2abcdef;
      end
      24: begin
        e.voltage_peak_done = 1'b1;
        e.voltage_peak = 27'h1123456;
      end
      default: if (b < 9) e.crossing_timeout[b-3] = 1'b1; else e.crossing_seen[b-9] = 1'b1;
    endcase
    return e;
  endfunction
  task automatic stop_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rdchk("status reset", ST, 32'h0020_8000);
    pinchk(1'b0);
    rdchk("mask reset", MK, 32'h0);
    wr(ST, 32'hffff_ffff, 4'hf);
    rdchk("status cleared", ST, R);
    pinchk(1'b1);
    // every plain event flag: set, masked off, enabled, cleared
    for (int b = 0; b < 25; b++) begin
      if (meter_flags_pkg::FLAG_MASK[b] && b != 15 && b != 19 && b != 20) begin
        pulse(ev_for(b));
        rdchk("flag set", ST, R | (32'h1 << b));
        chk("variant flag", rdat2, (b == 1) ? R : (R | (32'h1 << b)));
        pinchk(1'b1);
        wr(MK, 32'h1 << b, 4'hf);
        pinchk(1'b0);
        wr(ST, 32'h1 << b, 4'hf);
        pinchk(1'b1);
        wr(MK, 32'h0, 4'hf);
      end
    end
    rdchk("idle phases", meter_flags_pkg::IDX_PHASE_IDLE, 32'h111);
    chk("variant phases", rdat2, 32'h101);
    rdchk("event phases", meter_flags_pkg::IDX_PHASE_EVENT, 32'h1810);
    rdchk("curr peak", meter_flags_pkg::IDX_CURR_PEAK, 32'h02ab_cdef);
    rdchk("volt peak", meter_flags_pkg::IDX_VOLT_PEAK, 32'h0112_3456);
    // sticky flags, byte lanes and single bit clear
    pulse(ev_for(9) | ev_for(10));
    wr(ST, 32'h600, 4'hd);
    rdchk("lane kept", ST, R | 32'h600);
    wr(ST, 32'h200, 4'hf);
    rdchk("one cleared", ST, R | 32'h400);
    wr(ST, 32'h400, 4'hf);
    // a then c is an order error, a b c is not
    pulse('{volt_rise: 3'h1, default: '0});
    pulse('{volt_rise: 3'h4, default: '0});
    rdchk("order err", ST, R | 32'h8_0000);
    wr(ST, 32'h8_0000, 4'hf);
    pulse('{volt_rise: 3'h1, default: '0});
    pulse('{volt_rise: 3'h2, default: '0});
    pulse('{volt_rise: 3'h4, default: '0});
    rdchk("order ok", ST, R);
    // imbalance is strict greater than, either sign
    wr(meter_flags_pkg::IDX_THRESHOLD, 32'h64, 4'hf);
    mag(24'd250, 24'd150);
    rdchk("equal diff", ST, R);
    mag(24'd100, 24'd201);
    rdchk("over diff", ST, R | 32'h10_0000);
    chk("variant diff", rdat2, R);
    wr(ST, 32'h10_0000, 4'hf);
    // unmapped place reads zero
    wr(16'h0001, 32'hffff_ffff, 4'hf);
    rdchk("unmapped", 16'h0001, 32'h0);
    // software reset restores defaults, interrupt cannot be masked off
    wr(MK, 32'h1, 4'hf);
    wr(meter_flags_pkg::IDX_CONFIG, 32'h80, 4'h1);
    rdchk("sw reset", ST, 32'h0020_8000);
    rdchk("mask default", MK, 32'h0);
    pinchk(1'b0);
    // return to normal power state
    wr(ST, 32'h8000, 4'hf);
    pinchk(1'b1);
    @(posedge core_clk);
    pwr <= meter_flags_pkg::sleep_power_state;
    repeat (3) @(posedge core_clk);
    pwr <= meter_flags_pkg::normal_power_state;
    repeat (4) @(posedge core_clk);
    rdchk("power restart", ST, 32'h0020_8000);
    pinchk(1'b0);
    stop_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    #1_000_000;
    failures++;
    stop_test();
  end
endmodule // meter_event_status_flags_tb_top
